// *** sps_regs.vh ***
// Constants for the stored pattern output sequencer.
// Assumes plain Verilog-2005 and inclusion by bare name.
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// Register offsets (word-wide plain port)
`define SPS_ADDR_W 4
`define SPS_OFF_CTRL 4'h0
`define SPS_OFF_FIRST 4'h1
`define SPS_OFF_MASK 4'h2
`define SPS_OFF_MADDR 4'h3
`define SPS_OFF_MDATA 4'h4
`define SPS_OFF_MLINE 4'h5
`define SPS_OFF_STATUS 4'h6
`define SPS_OFF_LAST 4'h7

// Control field positions
`define SPS_CTRL_START 0
`define SPS_CTRL_STOP 1
`define SPS_CTRL_REL 2
`define SPS_CTRL_SLAVE 3
`define SPS_CTRL_IRQRES 4

// First-line field layout
`define SPS_FIRST_PAGE 10
`define SPS_PAGE_LINES 11'h400
`define SPS_LINES 12'h800
`define SPS_TOP_LINE 11'h7ff

// Pattern line layout: 32 data, 4 strobe, 2 inhibit-code pairs
`define SPS_DATA_W 32
`define SPS_STB_LSB 32
`define SPS_INH_LSB 36
`define SPS_LINE_W 40

// Reset values
`define SPS_RST_FIRST 11'h000
`define SPS_RST_MASK 32'h0000_0000
`define SPS_RST_LINE 40'h00_0000_0000

// Output clock divider: output clock tick every N system clocks
`define SPS_OCLK_DIV 8'h04

`endif

// *** sps_addr_map.v ***
// Maps a first-line setting to an absolute pattern memory line.
// Assumes callers supply the numbering mode as a static level.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_addr_map (
  relative_numbering,
  first_line_setting,
  reserve_line,
  start_line
);
  input wire relative_numbering;
  input wire [10:0] first_line_setting;
  input wire reserve_line;
  output reg [10:0] start_line;

  // Page bit is the top bit in both modes; clamp when a line is reserved
  always @* begin
    if (relative_numbering) begin
      // Page A at 0..1023, page B from 1024
      start_line = {first_line_setting[`SPS_FIRST_PAGE],
                    first_line_setting[9:0]}; // RULE5 RULE8
    end else begin
      start_line = first_line_setting; // RULE3
    end
    if (reserve_line && start_line == `SPS_TOP_LINE) begin
      start_line = `SPS_TOP_LINE - 11'h001; // RULE4
    end
  end
endmodule

// *** sps_sequencer.v ***
// Stored pattern output sequencer: memory, start logic, pod outputs.
// Assumes a register master on the same clock and pod pins that are
// resolved by the surroundings from the output enables.
//
// Overview of operation
// (RULE1) Start command runs memory from first line
// (RULE2) Slaved mode takes start line from controller
// (RULE3) Absolute first line ranges 0 through 2047
// (RULE4) Call handling enabled reserves one line
// (RULE5) Relative first line is page plus offset
// (RULE6) First line resets to page A line 0
// (RULE7) Memory holds 2048 lines, two pages
// (RULE8) Page B line 0 is absolute 1024
// (RULE9) Unmasked channel tri-states under inhibit
// (RULE10) Masked channel keeps driving under inhibit
// (RULE11) One mask bit per channel, reset zero
// (RULE12) Data grouped into pods of eight
// (RULE13) All pods update together on output clock
// (RULE14) Pattern data bits reset to zero
// (RULE15) One independent strobe bit per pod
// (RULE16) Strobes behave like data on output clock
// (RULE17) Strobe bit 1 asserts; default zero
// (RULE18) Leftmost pod pair uses top strobe bits
// (RULE19) Inhibit code aligned to output clock
// (RULE20) Code bit0 inhibits pod A, bit1 B
// (RULE21) Address advances one line per output clock
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_sequencer (
  clock,
  arst_n,
  reg_addr,
  reg_wdata,
  reg_write,
  reg_read,
  reg_rdata,
  ctl_start_valid,
  ctl_start_line,
  ext_inhibit,
  pod_data_out,
  pod_data_oe,
  pod_strobe_out,
  pod_strobe_oe,
  out_clock,
  running
);
  input wire clock;
  input wire arst_n;
  input wire [`SPS_ADDR_W-1:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_write;
  input wire reg_read;
  output reg [31:0] reg_rdata;
  input wire ctl_start_valid;
  input wire [10:0] ctl_start_line;
  input wire ext_inhibit;
  output reg [31:0] pod_data_out;
  output reg [31:0] pod_data_oe;
  output reg [3:0] pod_strobe_out;
  output reg [3:0] pod_strobe_oe;
  output reg out_clock;
  output wire running;

  localparam ST_IDLE = 2'd0;
  localparam ST_ARM = 2'd1;
  localparam ST_RUN = 2'd2;

  //////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  reg rst_s1_reg;
  reg rst_s2_reg;
  wire rst_n;

  // Release is synchronised; assertion stays asynchronous
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  reg inh_s1_reg;
  reg inh_s2_reg;

  // External inhibit is a pin; only the second stage is read
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inh_s1_reg <= 1'b0;
      inh_s2_reg <= 1'b0;
    end else begin
      inh_s1_reg <= ext_inhibit;
      inh_s2_reg <= inh_s1_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Output clock divider

  reg [7:0] div_reg;
  wire tick;

  assign tick = (div_reg == `SPS_OCLK_DIV - 8'h01);

  // Tick is a one-cycle enable; out_clock rises with each update
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h00;
      out_clock <= 1'b0;
    end else begin
      div_reg <= tick ? 8'h00 : div_reg + 8'h01;
      if (tick) begin
        out_clock <= 1'b1;
      end else if (div_reg == (`SPS_OCLK_DIV >> 1) - 8'h01) begin
        out_clock <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg [10:0] first_reg;
  reg relative_numbering_reg;
  reg slaved_start_mode_reg;
  reg irq_reserve_reg;
  reg [31:0] mask_reg;
  reg [10:0] maddr_reg;
  reg [39:0] mline_reg;
  reg [10:0] last_reg;
  reg start_req_reg;
  reg stop_req_reg;
  wire wr_ctrl;

  assign wr_ctrl = reg_write && reg_addr == `SPS_OFF_CTRL;

  // Start and stop are write-one pulses that last one cycle; one the run logic does not act on is lost
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= `SPS_RST_FIRST; // RULE6
      relative_numbering_reg <= 1'b0;
      slaved_start_mode_reg <= 1'b0;
      irq_reserve_reg <= 1'b0;
      mask_reg <= `SPS_RST_MASK; // RULE11
      maddr_reg <= 11'h000;
      mline_reg <= `SPS_RST_LINE;
      last_reg <= `SPS_TOP_LINE;
      start_req_reg <= 1'b0;
      stop_req_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        relative_numbering_reg <= reg_wdata[`SPS_CTRL_REL];
        slaved_start_mode_reg <= reg_wdata[`SPS_CTRL_SLAVE];
        irq_reserve_reg <= reg_wdata[`SPS_CTRL_IRQRES];
      end
      start_req_reg <= wr_ctrl && reg_wdata[`SPS_CTRL_START];
      stop_req_reg <= wr_ctrl && reg_wdata[`SPS_CTRL_STOP];
      if (reg_write) begin
        case (reg_addr)
          `SPS_OFF_FIRST: first_reg <= reg_wdata[10:0];
          `SPS_OFF_MASK: mask_reg <= reg_wdata;
          `SPS_OFF_MADDR: maddr_reg <= reg_wdata[10:0];
          `SPS_OFF_MDATA: mline_reg[31:0] <= reg_wdata;
          `SPS_OFF_MLINE: mline_reg[39:32] <= reg_wdata[7:0];
          `SPS_OFF_LAST: last_reg <= reg_wdata[10:0];
          default: ;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pattern memory, 2048 lines of flip-flops

  reg [39:0] pat_mem [0:2047]; // RULE7
  reg [11:0] clr_reg;
  wire clearing;
  wire mem_we;

  assign clearing = ~clr_reg[11];
  assign mem_we = reg_write && reg_addr == `SPS_OFF_MLINE;

  // After reset a sweep zeros every line, one per cycle; a start during it is dropped
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clr_reg <= 12'h000;
    end else if (clearing) begin
      clr_reg <= clr_reg + 12'h001;
    end
  end

  // Write commits data word and high byte to the addressed line
  always @(posedge clock) begin
    if (clearing) begin
      pat_mem[clr_reg[10:0]] <= `SPS_RST_LINE; // RULE14 RULE17
    end else if (mem_we) begin
      pat_mem[maddr_reg] <= {reg_wdata[7:0], mline_reg[31:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Run control and addressing

  reg [1:0] state_reg;
  reg [10:0] pc_reg;
  wire [10:0] own_start;
  wire [10:0] start_line;
  wire [10:0] stop_line;

  sps_addr_map u_map (
    .relative_numbering(relative_numbering_reg),
    .first_line_setting(first_reg),
    .reserve_line(irq_reserve_reg),
    .start_line(own_start)
  );

  // Slaved mode ignores the own setting
  assign start_line = slaved_start_mode_reg ? ctl_start_line
                                            : own_start; // RULE2
  // Reserved line shortens the usable range by one
  assign stop_line = (irq_reserve_reg && last_reg == `SPS_TOP_LINE) ?
                     `SPS_TOP_LINE - 11'h001 : last_reg; // RULE4
  assign running = (state_reg == ST_RUN);

  // Arm waits for an output clock tick; slaved start needs the strobe
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      pc_reg <= 11'h000;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req_reg && !clearing) begin
            state_reg <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (stop_req_reg) begin
            state_reg <= ST_IDLE;
          end else if (tick && (!slaved_start_mode_reg ||
                                ctl_start_valid)) begin
            pc_reg <= start_line; // RULE1
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop_req_reg) begin
            state_reg <= ST_IDLE;
          end else if (tick) begin
            // Wrap to the start line after the last usable line
            pc_reg <= (pc_reg == stop_line) ? start_line
                                            : pc_reg + 11'h001; // RULE21
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Pod outputs

  wire [39:0] line;
  reg [3:0] pod_off;
  integer i;
  integer j;

  // Continuous read, so a rewritten word is seen without a pc change
  assign line = pat_mem[pc_reg];

  // Inhibit code 2 bits per pod pair; bit0 = lower pod, bit1 = upper
  always @* begin
    pod_off[0] = line[`SPS_INH_LSB]; // RULE20
    pod_off[1] = line[`SPS_INH_LSB+1];
    pod_off[2] = line[`SPS_INH_LSB+2];
    pod_off[3] = line[`SPS_INH_LSB+3];
    for (i = 0; i < 4; i = i + 1) begin
      pod_off[i] = pod_off[i] | inh_s2_reg;
    end
  end

  // All pods and strobes change together on a tick while running
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pod_data_out <= 32'h0000_0000;
      pod_data_oe <= 32'h0000_0000;
      pod_strobe_out <= 4'h0;
      pod_strobe_oe <= 4'h0;
    end else if (!running) begin
      pod_data_oe <= 32'h0000_0000;
      pod_strobe_oe <= 4'h0;
    end else if (tick) begin
      pod_data_out <= line[`SPS_DATA_W-1:0]; // RULE13
      // Pod 3 is pod D, strobe bit 3 leftmost
      pod_strobe_out <= line[`SPS_STB_LSB+3:`SPS_STB_LSB]; // RULE15 RULE18
      pod_strobe_oe <= ~pod_off; // RULE16 RULE19
      for (j = 0; j < 32; j = j + 1) begin
        // Each pod is eight channels; mask 1 overrides inhibit
        pod_data_oe[j] <= ~pod_off[j/8] | mask_reg[j]; // RULE9 RULE10 RULE12
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register read port

  // Read data stands in the cycle after the strobe only
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_read) begin
      case (reg_addr)
        `SPS_OFF_CTRL: reg_rdata <= {27'h0, irq_reserve_reg,
            slaved_start_mode_reg, relative_numbering_reg, 2'b00};
        `SPS_OFF_FIRST: reg_rdata <= {21'h0, first_reg};
        `SPS_OFF_MASK: reg_rdata <= mask_reg;
        `SPS_OFF_MADDR: reg_rdata <= {21'h0, maddr_reg};
        `SPS_OFF_MDATA: reg_rdata <= pat_mem[maddr_reg][31:0];
        `SPS_OFF_MLINE: reg_rdata <= {24'h0, pat_mem[maddr_reg][39:32]};
        `SPS_OFF_STATUS: reg_rdata <= {16'h0, clearing, running,
            3'b000, pc_reg};
        `SPS_OFF_LAST: reg_rdata <= {21'h0, last_reg};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule

// *** sps_pod_model.sv ***
// Pod-side model of the device under test: resolves pod pins.
// Assumes drive values and enables come straight from the pods.
`timescale 1ns/1ps
module sps_pod_model (
  input wire clock,
  input wire [35:0] drv,
  input wire [35:0] oe,
  output wire [35:0] pin
);
  logic [35:0] last = 36'h0;
  // No pull-ups: a released pin flips every cycle, never holds old data
  always @(posedge clock) begin
    last <= pin;
  end
  assign pin = (drv & oe) | (~last & ~oe);
endmodule

// *** sps_sequencer_properties.sv ***
// Checker for the sequencer, watching its top ports only.
// Assumes one clock domain; bound onto every sequencer instance.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_sequencer_properties (
  input wire clock,
  input wire arst_n,
  input wire [`SPS_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [31:0] reg_rdata,
  input wire [31:0] pod_data_out,
  input wire [31:0] pod_data_oe,
  input wire [3:0] pod_strobe_out,
  input wire [3:0] pod_strobe_oe,
  input wire out_clock,
  input wire running
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // Steps of an output tick and of a stop request
  sequence s_tick;
    $rose(out_clock);
  endsequence
  sequence s_stop;
    reg_write && reg_addr == `SPS_OFF_CTRL && reg_wdata[1] && !reg_wdata[0];
  endsequence
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 0)
    else $error("read data not zero outside read slot");
  a_unmapped_read_zero: assert property ($past(reg_read) &&
    $past(reg_addr) > 4'h7 |-> reg_rdata == 32'h0)
    else $error("unmapped read returned data");
  a_tick_period_four: assert property (s_tick |=> (!$rose(out_clock)) [*3])
    else $error("output clock ticked early");
  a_data_on_tick: assert property ($changed(pod_data_out) |-> s_tick)
    else $error("data changed off the output clock");
  a_strobe_on_tick: assert property ($changed(pod_strobe_out) |-> s_tick)
    else $error("strobe changed off the output clock");
  a_reset_outputs_zero: assert property (!$past(arst_n) |->
    pod_data_out == 32'h0 && pod_strobe_out == 4'h0 && pod_data_oe == 32'h0)
    else $error("outputs not zero after reset");
  a_drive_needs_run: assert property ((|pod_data_oe || |pod_strobe_oe) |->
    running || $past(running))
    else $error("pods driven while idle");
  a_stop_goes_idle: assert property (s_stop |-> ##[1:8] !running)
    else $error("stop did not end the run");
endmodule

bind sps_sequencer sps_sequencer_properties u_props (.clock(clock),
  .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .pod_data_out(pod_data_out), .pod_data_oe(pod_data_oe),
  .pod_strobe_out(pod_strobe_out), .pod_strobe_oe(pod_strobe_oe),
  .out_clock(out_clock), .running(running));

// *** sps_sequencer_tb.sv ***
// Self-checking bench for the stored pattern output sequencer.
// Assumes the checker and the pod model are compiled beforehand.
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_sequencer_tb;
  reg clock = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg ctl_start_valid = 1'b0;
  reg [10:0] ctl_start_line = 11'h0;
  reg ext_inhibit = 1'b0;
  wire [31:0] rdata, dout, doe;
  wire [3:0] sout, soe;
  wire oclk, running;
  wire [35:0] pins;
  reg [39:0] mem [0:2047];
  reg [31:0] mask, got;
  int err_count = 0;
  int n_tests = 0;
  always #4 clock = ~clock;
  sps_sequencer DUT (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(rdata), .ctl_start_valid(ctl_start_valid),
    .ctl_start_line(ctl_start_line), .ext_inhibit(ext_inhibit),
    .pod_data_out(dout), .pod_data_oe(doe), .pod_strobe_out(sout),
    .pod_strobe_oe(soe), .out_clock(oclk), .running(running));
  sps_pod_model u_pod (.clock(clock), .drv({sout, dout}), .oe({soe, doe}),
    .pin(pins));
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [39:0] seen, input logic [39:0] want);
    n_tests++;
    if (seen !== want) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task conclude;
    $display("tests=%0d mismatches=%0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Expected enables: an inhibited pod keeps only its masked channels
  function automatic [31:0] exp_oe(input [3:0] c, input [31:0] m, input x);
    int b;
    for (b = 0; b < 32; b++) exp_oe[b] = !(c[b/8] | x) | m[b];
  endfunction
  // Bus tasks start right after an edge; a write leaves its strobe up
  task wr(input [3:0] a, input [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_read <= 1'b0;
    reg_write <= 1'b1;
    @(posedge clock);
  endtask
  task rd(input [3:0] a);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    got = rdata;
    @(posedge clock);
  endtask
  task line(input [10:0] a, input [39:0] v);
    mem[a] = v;
    wr(`SPS_OFF_MADDR, {21'h0, a});
    wr(`SPS_OFF_MDATA, v[31:0]);
    wr(`SPS_OFF_MLINE, {24'h0, v[39:32]});
  endtask
  // Wait out the clearing sweep, then first line, mask, an unmapped read and line 0x7fe must read zero
  task settle;
    int i;
    repeat (3) @(posedge clock);
    got = 32'hffff_ffff;
    i = 0;
    while (got[15] !== 1'b0 && i < 2000) begin
      rd(`SPS_OFF_STATUS);
      i++;
    end
    check(i < 2000, 1'b1);
    rd(`SPS_OFF_FIRST);
    check(got, 40'h0);
    rd(`SPS_OFF_MASK);
    check(got, 40'h0);
    rd(4'hc);
    check(got, 40'h0);
    wr(`SPS_OFF_MADDR, 32'h7fe);
    rd(`SPS_OFF_MDATA);
    check(got, 40'h0);
  endtask
  // Program four lines, start, then follow six ticks through the wrap
  task run(input [31:0] ctrl, input [10:0] first, input [10:0] s,
    input [10:0] lw, input [10:0] le, input x);
    logic [10:0] p;
    logic [31:0] w, eo;
    logic [3:0] se;
    logic pr;
    int i, k;
    p = s;
    for (i = 0; i < 4; i++) begin
      w = $urandom;
      line(p, {w[7:0], 32'($urandom)});
      p = p + 11'h1;
    end
    mask = $urandom;
    ext_inhibit <= x;
    wr(`SPS_OFF_FIRST, {21'h0, first});
    wr(`SPS_OFF_LAST, {21'h0, lw});
    wr(`SPS_OFF_MASK, mask);
    wr(`SPS_OFF_CTRL, ctrl | 32'h1);
    rd(`SPS_OFF_STATUS);
    p = s;
    k = 0;
    while (running !== 1'b1 && k < 64) begin
      @(negedge clock);
      k++;
    end
    check(running, 1'b1);
    for (i = 0; i < 6; i++) begin
      k = 0;
      do begin
        pr = oclk;
        @(negedge clock);
        k++;
      end while (!(oclk === 1'b1 && pr === 1'b0) && k < 16);
      check(k < 16, 1'b1);
      eo = exp_oe(mem[p][39:36], mask, x);
      se = ~(mem[p][39:36] | {4{x}});
      check(dout, mem[p][31:0]);
      check(sout, mem[p][35:32]);
      check(doe, eo);
      check(pins[31:0] & eo, mem[p][31:0] & eo);
      check(soe, se);
      check(pins[35:32] & se, mem[p][35:32] & se);
      p = (p == le) ? s : p + 11'h1;
    end
    @(posedge clock);
    wr(`SPS_OFF_CTRL, 32'h2);
    rd(`SPS_OFF_STATUS);
    k = 0;
    while (running !== 1'b0 && k < 16) begin
      @(posedge clock);
      k++;
    end
    check(running, 1'b0);
    @(negedge clock);
    check({soe, doe}, 40'h0);
    @(posedge clock);
    $display("run done ctrl=%h start=%h", ctrl, s);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Hang guard: a run that never ends counts as a failure
  initial begin
    #400000;
    err_count++;
    conclude;
  end
  // Main sequence
  initial begin
    int i;
    logic [10:0] s;
    void'($urandom(32'hdb99219a));
    for (i = 0; i < 2048; i++) mem[i] = 40'h0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    settle;
    $display("reset test done");
    s = 11'($urandom % 2000);
    run(32'h0, s, s, s + 11'h3, s + 11'h3, 1'b0);
    run(32'h0, 11'h7ff, 11'h7ff, 11'h7ff, 11'h7ff, 1'b1);
    s = 11'($urandom % 1000);
    run(32'h4, {1'b1, s[9:0]}, s + 11'h400, s + 11'h403, s + 11'h403,
      1'b1);
    run(32'h4, {1'b0, s[9:0]}, s, s + 11'h3, s + 11'h3, 1'b0);
    s = 11'($urandom % 2000);
    ctl_start_valid <= 1'b1;
    ctl_start_line <= s;
    run(32'h8, 11'h005, s, s + 11'h3, s + 11'h3, 1'b1);
    ctl_start_valid <= 1'b0;
    run(32'h10, 11'h7ff, 11'h7fe, 11'h7ff, 11'h7fe, 1'b0);
    // Reset in mid-run: pods let go at once, then settings fall back
    wr(`SPS_OFF_CTRL, 32'h1);
    rd(`SPS_OFF_STATUS);
    repeat (12) @(posedge clock);
    check(running, 1'b1);
    arst_n <= 1'b0;
    @(negedge clock);
    check({sout, dout}, 40'h0);
    check({soe, doe}, 40'h0);
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    settle;
    $display("mid-run reset test done");
    conclude;
  end
endmodule
